// ---- logic/dss_unit.sv ----
// Execute stage for doubleword shifts and subtracts with mode and overflow checks
`timescale 1ns/10ps
`include "dss_map.svh"
module dss_unit
    import dss_pkg::*;
#(
    parameter int WIDTH = 64
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RESETN,
    input  wire logic              ISSUE_VALID,
    input  wire logic [31:0]       INSTR,
    input  wire logic [WIDTH-1:0]  OPERAND_A,
    input  wire logic [WIDTH-1:0]  OPERAND_B,
    input  wire logic              MODE_64,
    input  wire logic              MODE_KERNEL,
    output logic                   RESULT_VALID,
    output logic [WIDTH-1:0]       RESULT,
    output logic [4:0]             DEST_REG,
    output logic                   DEST_WRITE,
    output logic                   EXC_RESERVED,
    output logic                   EXC_OVERFLOW
);
    localparam int SW = $clog2(WIDTH);

    logic [5:0]       opcode;
    logic [4:0]       dest_field;
    logic [4:0]       shift_amount_field;
    logic [5:0]       func;
    logic             claimed;
    dss_op_type       op;
    dss_shdir_type    dir;
    logic [SW-1:0]    amount;
    logic [WIDTH-1:0] shifted;
    logic [WIDTH:0]   diff_ext;
    logic             carry62;
    logic             carry63;
    logic             ovf;
    logic             allowed;

    logic             valid_q;
    logic             valid_d;
    logic [WIDTH-1:0] result_q;
    logic [WIDTH-1:0] result_d;
    logic [4:0]       dest_q;
    logic [4:0]       dest_d;
    logic             write_q;
    logic             write_d;
    logic             resv_q;
    logic             resv_d;
    logic             ovf_q;
    logic             ovf_d;

    // Field split of the register-format word
    assign opcode             = INSTR[`DSS_OPC_HI:`DSS_OPC_LO];
    assign dest_field         = INSTR[`DSS_RD_HI:`DSS_RD_LO];
    assign shift_amount_field = INSTR[`DSS_SA_HI:`DSS_SA_LO];
    assign func               = INSTR[`DSS_FN_HI:`DSS_FN_LO];

    function automatic logic is_ours(input logic [5:0] opc, input logic [5:0] fn);
        logic hit;
        hit = 1'b0;
        if (opc == `DSS_OPC_SPECIAL) begin
            case (fn)
                `DSS_FN_SLL_FIX, `DSS_FN_SLL_VAR, `DSS_FN_SLL_P32,
                `DSS_FN_SRA_FIX, `DSS_FN_SRA_VAR, `DSS_FN_SRA_P32,
                `DSS_FN_SRL_FIX, `DSS_FN_SRL_VAR, `DSS_FN_SRL_P32,
                `DSS_FN_SUB_TRAP, `DSS_FN_SUB_NOTRAP: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    assign claimed = is_ours(opcode, func);

    // Decode of direction and count source
    always_comb begin
        op     = DSS_OP_NONE;
        dir    = DSS_SH_LEFT;
        amount = '0;
        case (func)
            `DSS_FN_SLL_FIX: begin
                op     = DSS_OP_SHIFT;
                amount = {1'b0, shift_amount_field};
            end
            `DSS_FN_SLL_VAR: begin
                op     = DSS_OP_SHIFT;
                amount = OPERAND_A[SW-1:0];
            end
            `DSS_FN_SLL_P32: begin
                op     = DSS_OP_SHIFT;
                amount = `DSS_PLUS32 | {1'b0, shift_amount_field};
            end
            `DSS_FN_SRA_FIX: begin
                op     = DSS_OP_SHIFT;
                dir    = DSS_SH_ARITH;
                amount = {1'b0, shift_amount_field};
            end
            `DSS_FN_SRA_VAR: begin
                op     = DSS_OP_SHIFT;
                dir    = DSS_SH_ARITH;
                amount = OPERAND_A[SW-1:0];
            end
            `DSS_FN_SRA_P32: begin
                op     = DSS_OP_SHIFT;
                dir    = DSS_SH_ARITH;
                amount = `DSS_PLUS32 | {1'b0, shift_amount_field};
            end
            `DSS_FN_SRL_FIX: begin
                op     = DSS_OP_SHIFT;
                dir    = DSS_SH_LOGIC;
                amount = {1'b0, shift_amount_field};
            end
            `DSS_FN_SRL_VAR: begin
                op     = DSS_OP_SHIFT;
                dir    = DSS_SH_LOGIC;
                amount = OPERAND_A[SW-1:0];
            end
            `DSS_FN_SRL_P32: begin
                op     = DSS_OP_SHIFT;
                dir    = DSS_SH_LOGIC;
                amount = `DSS_PLUS32 | {1'b0, shift_amount_field};
            end
            `DSS_FN_SUB_TRAP, `DSS_FN_SUB_NOTRAP: begin
                op = DSS_OP_SUB;
            end
            default: begin
                op = DSS_OP_NONE;
            end
        endcase
    end

    dss_shifter #(
        .WIDTH (WIDTH)
    ) u_shifter (
        .value  (OPERAND_B),
        .amount (amount),
        .dir    (dir),
        .result (shifted)
    );

    // Carries taken from a borrow-as-add chain so both bit 62 and 63 are visible
    assign diff_ext = {1'b0, OPERAND_A} + {1'b0, ~OPERAND_B} + {{WIDTH{1'b0}}, 1'b1};
    assign carry63  = diff_ext[WIDTH];
    assign carry62  = OPERAND_A[WIDTH-1] ^ ~OPERAND_B[WIDTH-1] ^ diff_ext[WIDTH-1];
    assign ovf      = (func == `DSS_FN_SUB_TRAP) && (carry62 != carry63);
    assign allowed  = MODE_64 || MODE_KERNEL;

    always_comb begin
        valid_d  = ISSUE_VALID && claimed;
        dest_d   = dest_field;
        resv_d   = 1'b0;
        ovf_d    = 1'b0;
        write_d  = 1'b0;
        result_d = '0;
        if (ISSUE_VALID && claimed) begin
            if (!allowed) begin
                resv_d = 1'b1;
            end else if (op == DSS_OP_SUB) begin
                result_d = diff_ext[WIDTH-1:0];
                ovf_d    = ovf;
                write_d  = !ovf;
            end else begin
                result_d = shifted;
                write_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            valid_q  <= 1'b0;
            result_q <= '0;
            dest_q   <= 5'h00;
            write_q  <= 1'b0;
            resv_q   <= 1'b0;
            ovf_q    <= 1'b0;
        end else begin
            valid_q  <= valid_d;
            result_q <= result_d;
            dest_q   <= dest_d;
            write_q  <= write_d;
            resv_q   <= resv_d;
            ovf_q    <= ovf_d;
        end
    end

    assign RESULT_VALID = valid_q;
    assign RESULT       = result_q;
    assign DEST_REG     = dest_q;
    assign DEST_WRITE   = write_q;
    assign EXC_RESERVED = resv_q;
    assign EXC_OVERFLOW = ovf_q;
endmodule

// ---- pkg/dss_map.svh ----
// Offsets, field positions and function codes of the doubleword shift/subtract unit
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH
`define DSS_OPC_HI          31
`define DSS_OPC_LO          26
`define DSS_RA_HI           25
`define DSS_RA_LO           21
`define DSS_RB_HI           20
`define DSS_RB_LO           16
`define DSS_RD_HI           15
`define DSS_RD_LO           11
`define DSS_SA_HI           10
`define DSS_SA_LO           6
`define DSS_FN_HI           5
`define DSS_FN_LO           0
`define DSS_OPC_SPECIAL     6'h00
`define DSS_FN_SLL_FIX      6'h38
`define DSS_FN_SLL_VAR      6'h14
`define DSS_FN_SLL_P32      6'h3C
`define DSS_FN_SRA_FIX      6'h3B
`define DSS_FN_SRA_VAR      6'h17
`define DSS_FN_SRA_P32      6'h3F
`define DSS_FN_SRL_FIX      6'h3A
`define DSS_FN_SRL_VAR      6'h16
`define DSS_FN_SRL_P32      6'h3E
`define DSS_FN_SUB_TRAP     6'h2E
`define DSS_FN_SUB_NOTRAP   6'h2F
`define DSS_PLUS32          6'h20
`endif

// ---- pkg/dss_pkg.sv ----
// Types of the doubleword shift/subtract unit
package dss_pkg;
    typedef enum logic [1:0] {
        DSS_SH_LEFT  = 2'b00,
        DSS_SH_LOGIC = 2'b01,
        DSS_SH_ARITH = 2'b10
    } dss_shdir_type;
    typedef enum logic [1:0] {
        DSS_OP_NONE  = 2'b00,
        DSS_OP_SHIFT = 2'b01,
        DSS_OP_SUB   = 2'b10
    } dss_op_type;
endpackage

// ---- logic/dss_shifter.sv ----
// Combinational 64-bit barrel shifter, left, logical right and arithmetic right
`timescale 1ns/10ps
module dss_shifter
    import dss_pkg::*;
#(
    parameter int WIDTH = 64
) (
    input  wire logic [WIDTH-1:0]         value,
    input  wire logic [$clog2(WIDTH)-1:0] amount,
    input  dss_shdir_type                 dir,
    output logic      [WIDTH-1:0]         result
);
    logic signed [WIDTH-1:0] value_s;

    assign value_s = value;

    always_comb begin
        case (dir)
            DSS_SH_LEFT:  result = value << amount;
            DSS_SH_ARITH: result = value_s >>> amount;
            DSS_SH_LOGIC: result = value >> amount;
            default:      result = value >> amount;
        endcase
    end
endmodule

// ---- sim/dss_unit_sva.sv ----
// Assertion checker for the doubleword shift/subtract unit
`timescale 1ns/10ps
module dss_unit_sva #(
    parameter int WIDTH = 64
) (
    input wire logic             CLK_SYS,
    input wire logic             RESETN,
    input wire logic             ISSUE_VALID,
    input wire logic [31:0]      INSTR,
    input wire logic [WIDTH-1:0] OPERAND_A,
    input wire logic [WIDTH-1:0] OPERAND_B,
    input wire logic             MODE_64,
    input wire logic             MODE_KERNEL,
    input wire logic             RESULT_VALID,
    input wire logic [WIDTH-1:0] RESULT,
    input wire logic [4:0]       DEST_REG,
    input wire logic             DEST_WRITE,
    input wire logic             EXC_RESERVED,
    input wire logic             EXC_OVERFLOW
);
    logic [5:0]       fn, cnt;
    logic [WIDTH-1:0] sh_d, df_d;
    logic             claim, ok, sub, ovf_d;
    assign fn = INSTR[5:0];
    assign claim = ISSUE_VALID && INSTR[31:26] == 6'h00 && fn inside
        {6'h38, 6'h14, 6'h3C, 6'h3B, 6'h17, 6'h3F, 6'h3A, 6'h16, 6'h3E, 6'h2E, 6'h2F};
    assign ok = MODE_64 || MODE_KERNEL;
    assign sub = fn[5:1] == 5'b10111;
    // Plus-32 forms carry the top count bit in the function code
    assign cnt = fn[5] ? {fn[2], INSTR[10:6]} : OPERAND_A[5:0];
    always_comb begin
        sh_d = OPERAND_B >> cnt;
        if (fn[1:0] == 2'b11) sh_d = $signed(OPERAND_B) >>> cnt;
        if (fn[1:0] == 2'b00) sh_d = OPERAND_B << cnt;
        df_d = OPERAND_A - OPERAND_B;
        ovf_d = OPERAND_A[WIDTH-1] != OPERAND_B[WIDTH-1] && df_d[WIDTH-1] != OPERAND_A[WIDTH-1];
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    sequence s_take; claim && ok; endsequence
    sequence s_wrote; RESULT_VALID && DEST_WRITE && !EXC_RESERVED; endsequence
    a_take_answer: assert property (claim |=> RESULT_VALID)
        else $error("claimed word not answered");
    a_ignore_word: assert property (!claim |=> !RESULT_VALID && !EXC_RESERVED)
        else $error("unclaimed word answered");
    a_mode_refuse: assert property (claim && !ok
        |=> EXC_RESERVED && !DEST_WRITE && RESULT == '0) else $error("mode not refused");
    a_shift_value:
        assert property (s_take ##0 !sub |=> s_wrote ##0 RESULT == $past(sh_d))
        else $error("shift result wrong");
    a_sub_value: assert property (s_take ##0 sub
        |=> RESULT_VALID && !EXC_RESERVED && RESULT == $past(df_d)) else $error("bad difference");
    a_ovf_flag: assert property (s_take ##0 fn == 6'h2E
        |=> EXC_OVERFLOW == $past(ovf_d)) else $error("overflow flag wrong");
    a_ovf_nowrite: assert property (EXC_OVERFLOW |-> RESULT_VALID && !DEST_WRITE)
        else $error("overflow still wrote");
    a_notrap_write: assert property (s_take ##0 fn == 6'h2F
        |=> s_wrote ##0 !EXC_OVERFLOW) else $error("non-trapping form trapped");
endmodule
bind dss_unit dss_unit_sva #(.WIDTH(WIDTH)) sva_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
    .ISSUE_VALID(ISSUE_VALID), .INSTR(INSTR), .OPERAND_A(OPERAND_A), .OPERAND_B(OPERAND_B),
    .MODE_64(MODE_64), .MODE_KERNEL(MODE_KERNEL), .RESULT_VALID(RESULT_VALID), .RESULT(RESULT),
    .DEST_REG(DEST_REG), .DEST_WRITE(DEST_WRITE), .EXC_RESERVED(EXC_RESERVED),
    .EXC_OVERFLOW(EXC_OVERFLOW));

// ---- sim/dss_wb_model.sv ----
// Write-back stage model: register file loaded from the unit's results
`timescale 1ns/10ps
module dss_wb_model (
    input  wire logic        clk,
    input  wire logic        dest_write,
    input  wire logic [4:0]  dest_reg,
    input  wire logic [63:0] result,
    output logic      [63:0] gpr [32]
);
    // Cleared so a suppressed write leaves a known stale value
    logic [63:0] regs_q [32] = '{default: 64'h0};
    always @(posedge clk) begin
        if (dest_write === 1'b1) regs_q[dest_reg] <= result;
    end
    assign gpr = regs_q;
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the doubleword shift/subtract unit
`timescale 1ns/10ps
module tb_top;
    localparam logic [63:0] MIN = 64'h8000_0000_0000_0000;
    localparam logic [63:0] NEG = 64'h8000_0000_0000_0001;
    localparam logic [5:0] FNS [11] = '{6'h38, 6'h14, 6'h3C, 6'h3B, 6'h17, 6'h3F, 6'h3A,
        6'h16, 6'h3E, 6'h2E, 6'h2F};
    logic        clk = 1'b0, rst_n = 1'b0, iv = 1'b0, m64 = 1'b0, mkn = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [63:0] op_a = 64'h0, op_b = 64'h0, res;
    logic [63:0] regs [32];
    logic [71:0] notes [$];
    logic [4:0]  rd;
    logic        rv, dw, er, eo;
    int          miscompares = 0, cmp_count = 0;
    integer      seed = 14;
    always #5 clk = ~clk;
    dss_unit #(.WIDTH(64)) dut_u (.CLK_SYS(clk), .RESETN(rst_n), .ISSUE_VALID(iv),
        .INSTR(instr), .OPERAND_A(op_a), .OPERAND_B(op_b), .MODE_64(m64), .MODE_KERNEL(mkn),
        .RESULT_VALID(rv), .RESULT(res), .DEST_REG(rd), .DEST_WRITE(dw), .EXC_RESERVED(er),
        .EXC_OVERFLOW(eo));
    dss_wb_model wb_u (.clk(clk), .dest_write(dw), .dest_reg(rd), .result(res), .gpr(regs));
    function automatic logic [71:0] expect_of(logic [31:0] w, logic [63:0] a, b, logic ok);
        logic [5:0]  f, n;
        logic [63:0] r;
        logic        ov;
        f = w[5:0];
        n = f[5] ? {f[2], w[10:6]} : a[5:0];
        r = b >> n;
        if (f[1:0] == 2'b11) r = $signed(b) >>> n;
        if (f[1:0] == 2'b00) r = b << n;
        if (f[5:1] == 5'b10111) r = a - b;
        ov = f == 6'h2E && a[63] != b[63] && r[63] != a[63];
        if (!ok) return {64'h0, w[15:11], 3'b010};
        return {r, w[15:11], !ov, 1'b0, ov};
    endfunction
    task automatic issue(logic [5:0] f, logic [4:0] s, d, logic [63:0] a, b, logic m, k,
        logic [5:0] opc = 6'h00);
        @(posedge clk);
        iv <= 1'b1;
        instr <= {opc, 10'h064, d, s, f};
        op_a <= a;
        op_b <= b;
        m64 <= m;
        mkn <= k;
        if (opc == 6'h00) notes.push_back(expect_of({opc, 10'h064, d, s, f}, a, b, m || k));
    endtask
    task automatic test_done();
        $display("Compared %0d, mismatched %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(negedge clk) begin
        if (rv === 1'b1) begin
            cmp_count++;
            if (notes.size() == 0 || {res, rd, dw, er, eo} !== notes.pop_front()) begin
                miscompares++;
                $display("ERROR %0t result or flags differ", $time);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial begin
        int k;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // Per function: extreme counts, zero count fields (32 for plus-32 forms), then a refused mode, all back to back
        foreach (FNS[i]) begin
            issue(FNS[i], 5'h1F, 5'h02, ~MIN, NEG, 1'b1, 1'b0);
            issue(FNS[i], 5'h00, 5'h03, MIN, NEG, 1'b0, 1'b1);
            issue(FNS[i], 5'h03, 5'h04, ~MIN, NEG, 1'b0, 1'b0);
        end
        issue(6'h2F, 5'h00, 5'h05, MIN, 64'h1, 1'b1, 1'b1);
        // Trapped difference differs from the stored one, so a leaked write shows
        issue(6'h2E, 5'h00, 5'h05, MIN, 64'h2, 1'b1, 1'b1);
        issue(6'h2E, 5'h00, 5'h06, 64'h1, 64'h1, 1'b0, 1'b1, 6'h01);
        // Two edges let the write-back model take or skip the trapped result
        repeat (2) @(negedge clk);
        cmp_count++;
        if (regs[5] !== ~MIN) begin
            miscompares++;
            $display("ERROR %0t trapped subtract overwrote register", $time);
        end
        repeat (300) begin
            k = $unsigned($random(seed)) % 11;
            issue(FNS[k], 5'($random(seed)), 5'($random(seed)), {$random(seed), $random(seed)},
                {$random(seed), $random(seed)}, 1'($random(seed)), 1'($random(seed)),
                6'($random(seed) % 8 == 0));
        end
        @(posedge clk);
        iv <= 1'b0;
        for (int i = 0; i < 8 && notes.size() != 0; i++) @(posedge clk);
        if (notes.size() != 0) begin
            miscompares++;
            $display("ERROR %0t answers missing", $time);
        end
        test_done();
    end
endmodule
